// ---- tcd_pkg.sv ----
package tcd_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned REPLY_HZ = 70_000;
    // longest half bit, rounded down
    localparam int unsigned HALF_BIT_CYC = CLK_HZ / (2 * REPLY_HZ);
    localparam int unsigned DECODE_US = 100;
    localparam int unsigned DECODE_CYC = DECODE_US * CYC_PER_US;
    localparam int unsigned WRITE_US = 5000;
    localparam int unsigned SLOT_US = 2925;
    localparam int unsigned GAP_POSITIONS = 9;
    localparam int unsigned PAD_LO = 13;
    localparam int unsigned PAD_HI = 15;
    localparam int unsigned BUF_W = 144;
    localparam logic [7:0] PREAMBLE_LSBF = 8'h7f;
    localparam logic [4:0] BYPASS_ADDR = 5'h01;
    localparam logic [4:0] ADDR_EP = 5'h0a;
    localparam logic [4:0] ADDR_SET_TF = 5'h12;
    localparam logic [4:0] ADDR_SET_FR = 5'h13;
    localparam logic [4:0] ADDR_CLR_TF = 5'h14;
    localparam logic [4:0] ADDR_CLR_FR = 5'h15;
    localparam logic [2:0] CMD_READ = 3'h6;
    localparam logic [2:0] CMD_WRITE = 3'h5;
    localparam logic [2:0] CMD_MISC = 3'h7;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic FR_RESET = 1'h1;
    localparam logic TF_RESET = 1'h0;
    // gap masks: bit n-1 set when position n carries a gap
    localparam logic [8:0] PAT_N1_1 = 9'h02f;
    localparam logic [8:0] PAT_F1_1 = 9'h0b5;
    localparam logic [8:0] PAT_N1_2 = 9'h01f;
    localparam logic [8:0] PAT_F1_2 = 9'h075;
    localparam logic [8:0] PAT_N1_4 = 9'h037;
    localparam logic [8:0] PAT_F1_4 = 9'h0d5;
    localparam logic [8:0] PAT_N16_1 = 9'h0ab;
    localparam logic [8:0] PAT_F16_1 = 9'h0ad;
    localparam logic [8:0] PAT_N16_2 = 9'h06b;
    localparam logic [8:0] PAT_F16_2 = 9'h06d;
    localparam logic [8:0] PAT_N16_4 = 9'h03b;
    localparam logic [8:0] PAT_F16_4 = 9'h03d;
    localparam logic [8:0] PAT_N64_1 = 9'h05b;
    localparam logic [8:0] PAT_F64_1 = 9'h05d;
    localparam logic [8:0] BYPASS_NORMAL_PATTERN = 9'h057;
    localparam logic [8:0] BYPASS_FAST_PATTERN = 9'h155;
    typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_SEND} tcd_phase_type;
    typedef enum logic [1:0] {CHK_NONE, CHK_STORED, CHK_COMPUTED}
        tcd_check_type;
endpackage

// ---- tcd_crc16.sv ----
`timescale 1ns/1ps
module tcd_crc16 #(
    parameter logic [15:0] POLY = tcd_pkg::CRC_POLY,
    parameter logic [15:0] INIT = tcd_pkg::CRC_INIT
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clear,
    input wire logic enable,
    input wire logic bitIn,
    output logic [15:0] crc
);
    import tcd_pkg::*;
    typedef struct packed {
        logic [15:0] crc;
    } tcd_crc_state_type;
    tcd_crc_state_type s_q, s_d;

    // reflected shift, so the value leaves least significant bit first
    always_comb
    begin
        s_d = s_q;
        if (clear)
            s_d.crc = INIT;
        else if (enable)
            s_d.crc = (s_q.crc >> 1) ^ ((s_q.crc[0] ^ bitIn) ? POLY : 16'h0000);
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '{crc: INIT};
        else
            s_q <= s_d;
    end

    assign crc = s_q.crc;
endmodule // tcd_crc16

// ---- tcd_gap_decoder.sv ----
`timescale 1ns/1ps
module tcd_gap_decoder (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic gapPin,
    output logic patValid,
    output logic [8:0] pattern
);
    import tcd_pkg::*;
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic busy;
        logic measuring;
        logic [15:0] slotLen;
        logic [15:0] cnt;
        logic [3:0] pos;
        logic [8:0] mask;
        logic valid;
    } tcd_gap_state_type;
    tcd_gap_state_type s_q, s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.s1 = gapPin;
        s_d.s2 = s_q.s1;
        s_d.prev = s_q.s2;
        s_d.valid = 1'b0;
        if (!s_q.busy)
        begin
            if (s_q.s2 && !s_q.prev)
            begin
                s_d.busy = 1'b1;
                s_d.measuring = 1'b1;
                s_d.cnt = 16'h0001;
                s_d.mask = 9'h001;
            end
        end
        else if (s_q.cnt == 16'hffff)
            s_d.busy = 1'b0; // stuck carrier gap: give up quietly
        else if (s_q.measuring)
        begin
            // first gap is one position wide and sets the time base
            s_d.cnt = s_q.cnt + 16'h0001;
            if (!s_q.s2)
            begin
                s_d.measuring = 1'b0;
                s_d.slotLen = s_q.cnt;
                s_d.cnt = 16'h0000;
                s_d.pos = 4'h1;
            end
        end
        else
        begin
            s_d.cnt = s_q.cnt + 16'h0001;
            // sample mid-position so edge jitter does not matter
            if (s_q.cnt == (s_q.slotLen >> 1))
                s_d.mask[s_q.pos] = s_q.s2;
            if (s_q.cnt >= s_q.slotLen - 16'h0001)
            begin
                s_d.cnt = 16'h0000;
                if (s_q.pos == 4'(GAP_POSITIONS - 1))
                begin
                    s_d.busy = 1'b0;
                    s_d.valid = 1'b1;
                end
                else
                    s_d.pos = s_q.pos + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign patValid = s_q.valid;
    assign pattern = s_q.mask;
endmodule // tcd_gap_decoder

// ---- tcd_command_reply.sv ----
`timescale 1ns/1ps
module tcd_command_reply #(
    parameter logic [31:0] TAG_ID = 32'h5a3c_0f96, // arbitrary value
    parameter int unsigned WRITE_CYC = tcd_pkg::WRITE_US * tcd_pkg::CYC_PER_US,
    parameter int unsigned SLOT_CYC = tcd_pkg::SLOT_US * tcd_pkg::CYC_PER_US
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic gapPin,
    input wire logic cmdValid,
    input wire logic [2:0] cmdCode,
    input wire logic [4:0] cmdAddr,
    input wire logic [31:0] cmdData,
    input wire logic [15:0] cmdCheck,
    input wire logic cmdParity,
    input wire logic matchOk,
    input wire logic fieldLenSel0,
    input wire logic fieldLenSel1,
    output logic txOut,
    output logic txActive,
    output logic downlinkFast,
    output logic [6:0] slotLimit,
    output logic [2:0] repeatLimit,
    output logic quickReadArmed,
    output logic fastReadFlag,
    output logic talkFirstFlag
);
    import tcd_pkg::*;
    typedef struct packed {
        tcd_phase_type ph;
        logic [23:0] dly;
        logic [8:0] halfCnt;
        logic half;
        logic [7:0] idx;
        logic [7:0] len;
        logic [BUF_W-1:0] shiftBuf;
        logic [7:0] crcFrom;
        logic skipPad;
        tcd_check_type chk;
        logic [15:0] stored;
        logic inChk;
        logic txBit;
        logic [2:0] tc;
        logic frFlag;
        logic tfFlag;
        logic fast;
        logic [6:0] slots;
        logic [2:0] repLim;
        logic [2:0] repLeft;
        logic qrArmed;
        logic qrNext;
        logic [31:0][31:0] data;
        logic [31:0][15:0] stored_check;
    } tcd_reply_state_type;
    tcd_reply_state_type s_q, s_d;

    logic patValid;
    logic [8:0] pattern;
    logic [15:0] crcOut;
    logic crcClr, crcEn, crcDin;
    logic [4:0] gCls;
    logic gReq, gByp;
    logic [6:0] gSlots;
    logic [2:0] gRep;
    logic [5:0] slotIdx;
    logic [BUF_W-1:0] qrBuf;
    logic [7:0] qrLen;
    logic [3:0] tp;
    logic accept, took, tick, ld, parOk;
    logic [7:0] nxt;
    logic [15:0] chkVal;
    logic [BUF_W-1:0] ldBuf;
    logic [7:0] ldLen;
    logic ldSkip;
    tcd_check_type ldChk;
    logic [15:0] ldStored;
    logic [23:0] ldDly;

    tcd_gap_decoder u_gap (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .gapPin(gapPin),
        .patValid(patValid),
        .pattern(pattern)
    );

    tcd_crc16 u_crc (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clear(crcClr),
        .enable(crcEn),
        .bitIn(crcDin),
        .crc(crcOut)
    );

    // code: {known, slot select, repeat select}; anything else but the two bypass patterns is dropped
    always_comb
    begin
        case (pattern)
            PAT_N1_1, PAT_F1_1: gCls = 5'h10;
            PAT_N1_2, PAT_F1_2: gCls = 5'h11;
            PAT_N1_4, PAT_F1_4: gCls = 5'h12;
            PAT_N16_1, PAT_F16_1: gCls = 5'h14;
            PAT_N16_2, PAT_F16_2: gCls = 5'h15;
            PAT_N16_4, PAT_F16_4: gCls = 5'h16;
            PAT_N64_1, PAT_F64_1: gCls = 5'h18;
            default: gCls = 5'h00;
        endcase
        gByp = (pattern == BYPASS_NORMAL_PATTERN)
            || (pattern == BYPASS_FAST_PATTERN);
        gReq = gCls[4];
        case (gCls[3:2])
            2'h1: gSlots = 7'd16;
            2'h2: gSlots = 7'd64;
            default: gSlots = 7'd1;
        endcase
        gRep = 3'h1 << gCls[1:0];
        slotIdx = TAG_ID[5:0] & 6'(gSlots - 7'd1);
    end

    // quick-read frame, first bit at index 0
    always_comb
    begin
        tp = {s_q.tc[0] ^ s_q.tc[1] ^ s_q.tc[2] ^ fieldLenSel0 ^ fieldLenSel1,
            fieldLenSel1, fieldLenSel0, 1'b0};
        qrBuf = {s_q.data[5], s_q.data[4], s_q.data[3], s_q.data[1], 1'b0,
            tp, s_q.tc, PREAMBLE_LSBF};
        case ({fieldLenSel1, fieldLenSel0})
            2'h0: qrLen = 8'd80;
            2'h1: qrLen = 8'd112;
            default: qrLen = 8'd144;
        endcase
    end

    assign tick = (s_q.halfCnt == 9'(HALF_BIT_CYC - 1));
    assign nxt = s_q.idx + 8'h01;
    assign chkVal = (s_q.chk == CHK_STORED) ? s_q.stored : crcOut;
    assign accept = (s_q.ph == PH_IDLE) || (s_q.ph == PH_WAIT && s_q.qrArmed);
    assign parOk = ~^{cmdCode, cmdAddr, cmdParity};

    always_comb
    begin
        s_d = s_q;
        ld = 1'b0;
        ldBuf = '0;
        ldLen = 8'd48;
        ldSkip = 1'b1;
        ldChk = CHK_STORED;
        ldStored = 16'h0000;
        ldDly = 24'(DECODE_CYC);
        crcClr = 1'b0;
        crcEn = 1'b0;
        crcDin = 1'b0;
        took = 1'b0;
        if (matchOk && s_q.qrArmed)
        begin
            s_d.qrArmed = 1'b0;
            if (s_q.ph == PH_WAIT)
                s_d.ph = PH_IDLE;
        end
        if (patValid && accept && (gReq || gByp))
        begin
            took = 1'b1;
            s_d.fast = ~pattern[1];
            if (gReq)
            begin
                s_d.slots = gSlots;
                s_d.repLim = gRep;
                s_d.repLeft = gRep - 3'h1;
                s_d.qrArmed = 1'b1;
                s_d.qrNext = 1'b1;
                s_d.ph = PH_WAIT;
                s_d.dly = 24'(DECODE_CYC) + 24'(slotIdx) * 24'(SLOT_CYC);
            end
            else
            begin
                ld = 1'b1;
                ldBuf[47:0] = {s_q.data[1], 3'b000, BYPASS_ADDR, PREAMBLE_LSBF};
                ldStored = s_q.stored_check[1];
            end
        end
        else if (cmdValid && accept)
        begin
            took = 1'b1;
            ldBuf[47:0] = {s_q.data[cmdAddr], 3'b000, cmdAddr, PREAMBLE_LSBF};
            ldStored = s_q.stored_check[cmdAddr];
            if (cmdAddr == 5'd0 || cmdAddr == 5'd2)
                ldChk = CHK_COMPUTED;
            case (cmdCode)
                CMD_READ: ld = parOk;
                CMD_WRITE:
                begin
                    // tag identifier block is fixed and never rewritten
                    ld = (cmdAddr != 5'd1);
                    s_d.data[cmdAddr] = ld ? cmdData : s_q.data[cmdAddr];
                    s_d.stored_check[cmdAddr] = ld ? cmdCheck : s_q.stored_check[cmdAddr];
                    ldBuf[47:0] = {cmdData, 3'b000, cmdAddr, PREAMBLE_LSBF};
                    ldStored = cmdCheck;
                    ldDly = 24'(WRITE_CYC);
                end
                CMD_MISC:
                begin
                    ld = parOk;
                    ldSkip = 1'b0;
                    ldChk = CHK_COMPUTED;
                    ldDly = 24'(WRITE_CYC);
                    ldBuf[47:0] = {s_q.data[0], 8'h00, PREAMBLE_LSBF};
                    case (cmdAddr)
                        ADDR_SET_TF: s_d.tfFlag = parOk ? 1'b1 : s_q.tfFlag;
                        ADDR_SET_FR: s_d.frFlag = parOk ? 1'b1 : s_q.frFlag;
                        ADDR_CLR_TF: s_d.tfFlag = parOk ? 1'b0 : s_q.tfFlag;
                        ADDR_CLR_FR: s_d.frFlag = parOk ? 1'b0 : s_q.frFlag;
                        ADDR_EP:
                        begin
                            ldLen = 8'd8;
                            ldChk = CHK_NONE;
                            ldDly = 24'(DECODE_CYC);
                        end
                        default: ld = 1'b0;
                    endcase
                end
                default: ld = 1'b0;
            endcase
        end
        if (ld)
        begin
            s_d.shiftBuf = ldBuf;
            s_d.len = ldLen;
            s_d.crcFrom = 8'd8;
            s_d.skipPad = ldSkip;
            s_d.chk = ldChk;
            s_d.stored = ldStored;
            s_d.dly = ldDly;
            s_d.ph = PH_WAIT;
            s_d.qrNext = 1'b0;
            s_d.qrArmed = 1'b0;
        end
        if (!took)
        begin
            case (s_q.ph)
                PH_WAIT:
                begin
                    s_d.dly = s_q.dly - 24'h000001;
                    if (s_q.dly == 24'h000000)
                    begin
                        s_d.ph = PH_SEND;
                        s_d.idx = 8'h00;
                        s_d.half = 1'b0;
                        s_d.halfCnt = 9'h000;
                        s_d.inChk = 1'b0;
                        s_d.txBit = PREAMBLE_LSBF[0];
                        crcClr = 1'b1;
                        if (s_q.qrNext)
                        begin
                            s_d.shiftBuf = qrBuf;
                            s_d.len = qrLen;
                            s_d.crcFrom = 8'd16;
                            s_d.skipPad = 1'b0;
                            s_d.chk = CHK_COMPUTED;
                            s_d.tc = s_q.tc + 3'h1;
                        end
                    end
                end
                PH_SEND:
                begin
                    s_d.halfCnt = tick ? 9'h000 : s_q.halfCnt + 9'h001;
                    if (tick && !s_q.half)
                    begin
                        // manchester: second half is the inverse
                        s_d.half = 1'b1;
                        s_d.txBit = ~s_q.txBit;
                    end
                    else if (tick)
                    begin
                        s_d.half = 1'b0;
                        if (nxt < s_q.len)
                        begin
                            s_d.idx = nxt;
                            s_d.txBit = s_q.shiftBuf[nxt];
                            crcDin = s_q.shiftBuf[nxt];
                            // feed at bit start so the value is final at end
                            crcEn = !s_q.inChk && nxt >= s_q.crcFrom
                                && !(s_q.skipPad && nxt >= 8'(PAD_LO)
                                && nxt <= 8'(PAD_HI));
                        end
                        else if (!s_q.inChk && s_q.chk != CHK_NONE)
                        begin
                            s_d.inChk = 1'b1;
                            s_d.idx = 8'h00;
                            s_d.len = 8'd16;
                            s_d.shiftBuf[15:0] = chkVal;
                            s_d.txBit = chkVal[0];
                        end
                        else if (s_q.qrNext && s_q.qrArmed
                            && s_q.repLeft != 3'h0)
                        begin
                            s_d.txBit = 1'b0;
                            s_d.ph = PH_WAIT;
                            s_d.dly = 24'(s_q.slots) * 24'(SLOT_CYC);
                            s_d.repLeft = s_q.repLeft - 3'h1;
                        end
                        else
                        begin
                            s_d.txBit = 1'b0;
                            s_d.ph = PH_IDLE;
                            s_d.qrArmed = 1'b0;
                        end
                    end
                end
                default: s_d.ph = PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_q <= '0;
            s_q.data[1] <= TAG_ID;
            s_q.frFlag <= FR_RESET;
            s_q.tfFlag <= TF_RESET;
            s_q.slots <= 7'd1;
            s_q.repLim <= 3'd1;
        end
        else
            s_q <= s_d;
    end

    assign txOut = s_q.txBit;
    assign txActive = (s_q.ph == PH_SEND);
    assign downlinkFast = s_q.fast;
    assign slotLimit = s_q.slots;
    assign repeatLimit = s_q.repLim;
    assign quickReadArmed = s_q.qrArmed;
    assign fastReadFlag = s_q.frFlag;
    assign talkFirstFlag = s_q.tfFlag;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_preamble_opens: assert property ($rose(txActive) |-> txOut [*8])
        else $error("reply does not open with preamble ones");
    a_pad_bits_zero: assert property (txActive && !s_q.inChk && s_q.skipPad
        && s_q.idx >= 8'd13 && s_q.idx <= 8'd15 && !s_q.half |-> !txOut)
        else $error("pad bit after block number is not zero");
    a_bypass_speed: assert property (patValid && accept
        && pattern == BYPASS_FAST_PATTERN |=> downlinkFast && !quickReadArmed)
        else $error("fast bypass did not select fast speed");
    a_request_limits: assert property (patValid && accept
        && pattern == PAT_N64_1 |=> slotLimit == 7'd64 && repeatLimit == 3'd1
        && !downlinkFast && quickReadArmed)
        else $error("slot 64 request decoded wrongly");
    a_unknown_ignored: assert property (patValid && !gReq && !gByp
        && s_q.ph == PH_IDLE && !cmdValid |=> s_q.ph == PH_IDLE)
        else $error("unknown gap pattern produced activity");
    a_stored_check: assert property (tick && s_q.half && !s_q.inChk
        && nxt >= s_q.len && s_q.chk == CHK_STORED
        |=> s_q.shiftBuf[15:0] == $past(s_q.stored))
        else $error("stored check not sent unchanged");
    a_tp_parity: assert property ($rose(txActive) && s_q.qrNext
        |-> ^s_q.shiftBuf[14:8] == 1'b0)
        else $error("count and parameter nibble parity is odd");
    a_match_stops: assert property (matchOk && s_q.qrArmed
        && s_q.ph == PH_WAIT && !patValid && !cmdValid
        |=> s_q.ph == PH_IDLE && !quickReadArmed)
        else $error("matching code did not stop repeats");
    a_write_stores: assert property (cmdValid && accept && !took
        || cmdValid && accept && !patValid && cmdCode == CMD_WRITE
        && cmdAddr != 5'd1 |=> s_q.stored_check[$past(cmdAddr)] == $past(cmdCheck))
        else $error("write check not stored");
    a_manchester: assert property (txActive && tick && !s_q.half
        |=> txOut == !$past(txOut))
        else $error("manchester half not inverted");

    c_quick_reply: cover property ($rose(txActive) && s_q.qrNext);
    c_bypass_reply: cover property (patValid && accept && gByp);
    c_write_reply: cover property (cmdValid && accept && cmdCode == CMD_WRITE);
endmodule // tcd_command_reply

// ---- tcd_interrogator.sv ----
`timescale 1ns/1ps
module tcd_interrogator #(
    parameter int POS_CYC = 200
) (
    input wire logic clk_sys,
    input wire logic send,
    input wire logic [8:0] mask,
    output logic gapPin,
    output logic busy
);
    int cnt = 0;
    logic [8:0] m = '0;
    initial gapPin = 1'b0;
    initial busy = 1'b0;
    always @(posedge clk_sys)
    begin
        if (!busy && send)
        begin
            busy <= 1'b1;
            m <= mask;
            cnt <= 0;
        end
        else if (busy)
        begin
            // gap a little short of a position so neighbours stay apart
            gapPin <= (cnt < 9 * POS_CYC) && m[cnt / POS_CYC]
                && (cnt % POS_CYC < POS_CYC - 10);
            cnt <= cnt + 1;
            if (cnt == 12 * POS_CYC)
                busy <= 1'b0;
        end
    end
endmodule // tcd_interrogator

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import tcd_pkg::*;
    localparam logic [31:0] TAG = 32'h1b2d_3c4e; // arbitrary value
    logic clk_sys, arst_n, cmdValid, cmdParity, send, busy, gapPin;
    logic matchOk, fieldLenSel0, fieldLenSel1;
    logic [2:0] cmdCode;
    logic [4:0] cmdAddr;
    logic [31:0] cmdData;
    logic [15:0] cmdCheck;
    logic [8:0] mask;
    logic txOut, txActive, downlinkFast, quickReadArmed;
    logic fastReadFlag, talkFirstFlag;
    logic [6:0] slotLimit;
    logic [2:0] repeatLimit;
    int err_count = 0;
    int samples_checked = 0;
    tcd_command_reply #(.TAG_ID(TAG), .WRITE_CYC(200), .SLOT_CYC(300))
        u_tcd_command_reply (.clk_sys, .arst_n, .gapPin, .cmdValid,
        .cmdCode, .cmdAddr, .cmdData, .cmdCheck, .cmdParity, .matchOk,
        .fieldLenSel0, .fieldLenSel1, .txOut, .txActive, .downlinkFast,
        .slotLimit, .repeatLimit, .quickReadArmed, .fastReadFlag,
        .talkFirstFlag);
    tcd_interrogator #(.POS_CYC(200)) u_tcd_interrogator (.clk_sys,
        .send, .mask, .gapPin, .busy);
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [159:0] e,
        input logic [159:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h got %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [4:0] a,
        input logic [31:0] d, input logic [15:0] k);
        // strobe stands for a decoded command, calibration already spent
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdCode <= c;
        cmdAddr <= a;
        cmdData <= d;
        cmdCheck <= k;
        cmdParity <= ^{c, a};
        @(posedge clk_sys);
        cmdValid <= 1'b0;
    endtask
    task automatic gaps(input logic [8:0] m);
        @(posedge clk_sys);
        send <= 1'b1;
        mask <= m;
        @(posedge clk_sys);
        send <= 1'b0;
        tick(12 * 200 + 20);
    endtask
    // samples mid first half of each Manchester bit
    task automatic frame(input logic [159:0] e, input int n, input int lim);
        logic [159:0] f;
        int k;
        f = '0;
        k = 0;
        while (txActive !== 1'b1 && k < lim)
        begin
            tick(1);
            k++;
        end
        for (k = 0; k < 160; k++)
        begin
            tick(142);
            if (txActive !== 1'b1)
                break;
            f[k] = txOut;
            tick(428);
        end
        chk("frame", e, f);
        chk("bits", 160'(n), 160'(k));
    endtask
    initial
    begin
        {arst_n, cmdValid, cmdParity, send, matchOk} = '0;
        {fieldLenSel0, fieldLenSel1, cmdCode, cmdAddr} = '0;
        {cmdData, cmdCheck, mask} = '0;
        tick(16);
        @(posedge clk_sys);
        arst_n <= 1'b1;
        tick(2);
        chk("rst", {fastReadFlag, talkFirstFlag, slotLimit, repeatLimit,
            txActive}, {1'b1, 1'b0, 7'h01, 3'h1, 1'b0});
        cmd(CMD_WRITE, 5'h07, 32'hc3a5_1e69, 16'hb24d);
        frame({16'hb24d, 32'hc3a5_1e69, 3'h0, 5'h07,
            PREAMBLE_LSBF}, 64, 9000);
        gaps(9'h0f1);
        frame('0, 0, 4500);
        gaps(BYPASS_FAST_PATTERN);
        chk("fast", 160'(downlinkFast), 160'h1);
        frame({16'h0000, TAG, 3'h0, BYPASS_ADDR, PREAMBLE_LSBF},
            64, 9000);
        gaps(PAT_N64_1);
        chk("limits", {downlinkFast, slotLimit, repeatLimit,
            quickReadArmed}, {1'b0, 7'h40, 3'h1, 1'b1});
        @(posedge clk_sys);
        matchOk <= 1'b1;
        @(posedge clk_sys);
        matchOk <= 1'b0;
        tick(1);
        chk("match", 160'(quickReadArmed), 160'h0);
        @(posedge clk_sys);
        arst_n <= 1'b0;
        tick(2);
        arst_n <= 1'b1;
        tick(2);
        chk("rst2", {slotLimit, txActive, quickReadArmed}, {7'h01, 2'b00});
        cmd(CMD_MISC, ADDR_CLR_FR, 32'h0, 16'h0);
        tick(3);
        chk("clrfr", 160'(fastReadFlag), 160'h0);
        end_of_test();
    end
    initial
    begin
        tick(100000);
        err_count++;
        end_of_test();
    end
endmodule // tb
